//--- shared/dfps_pkg.sv
`default_nettype none
package dfps_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_COMMAND   = 8'hB9;
  localparam logic [7:0] ADDR_DATA_ONE  = 8'hBC;
  localparam logic [7:0] ADDR_DATA_TWO  = 8'hBD;
  localparam logic [7:0] ADDR_DATA_THR  = 8'hBE;
  localparam logic [7:0] ADDR_DATA_FOUR = 8'hBF;
  localparam logic [7:0] ADDR_TIM_LOW   = 8'hC4;
  localparam logic [7:0] ADDR_TIM_HIGH  = 8'hC5;
  localparam logic [7:0] ADDR_PAGE      = 8'hC6;
  localparam logic [7:0] ADDR_TIM_THIRD = 8'hC7;

  // reset values
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [15:0] TIMING_RESET  = 16'h0452;
  localparam logic [7:0]  THIRD_RESET   = 8'hC9;

  // command codes
  localparam logic [7:0] CMD_READ      = 8'h01;
  localparam logic [7:0] CMD_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_INTERNAL  = 8'h03;
  localparam logic [7:0] CMD_VERIFY    = 8'h04;
  localparam logic [7:0] CMD_ERASE     = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] CMD_DONE      = 8'h00;
  localparam logic [7:0] VERIFY_FAIL   = 8'hFF;

  // array geometry
  localparam int         PAGE_COUNT  = 160;
  localparam logic [7:0] PAGE_LAST   = 8'h9F;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  // timing: one tick is half the timing word, i.e. 50 us
  localparam int TICK_US       = 50;
  localparam int PROG_TIME_US  = 250;
  localparam int ERASE_TIME_US = 20000;
  localparam logic [8:0] PROG_TICKS  = 9'(PROG_TIME_US / TICK_US);
  localparam logic [8:0] ERASE_TICKS = 9'(ERASE_TIME_US / TICK_US);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_APPLY = 2'b11
  } dfps_state_type;
endpackage : dfps_pkg
`default_nettype wire

//--- rtl/dfps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module dfps_sequencer
  import dfps_pkg::*;
#(
  parameter int PAGES = PAGE_COUNT
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata,
  // core stall
  output var  logic       busy
);

  function automatic logic page_ok(input logic [7:0] p);
    page_ok = (p <= PAGE_LAST) && (int'(p) < PAGES);
  endfunction : page_ok

  logic [31:0]    mem_reg [PAGES];
  logic [7:0]     data_reg [4];
  logic [7:0]     command_reg;
  logic [7:0]     page_select_reg;
  logic [7:0]     erase_timing_low;
  logic [7:0]     erase_timing_high;
  logic [7:0]     third_timing_reg;
  dfps_state_type state_reg;
  logic [7:0]     op_reg;
  logic [7:0]     op_page_reg;
  logic [31:0]    op_data_reg;
  logic [15:0]    pre_cnt_reg;
  logic [8:0]     tick_cnt_reg;
  logic [8:0]     tick_target_reg;

  logic        idle;
  logic        cmd_wr;
  logic [31:0] data_word;
  logic [31:0] page_word;
  logic        page_match;
  logic [15:0] timing_word;
  logic [15:0] half_word;
  logic        tick;
  logic        timed_cmd;

  assign idle        = (state_reg == ST_IDLE);
  assign cmd_wr      = ce && sfr_wr && idle && (sfr_addr == ADDR_COMMAND);
  assign data_word   = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
  assign page_word   = page_ok(page_select_reg) ? mem_reg[page_select_reg] : ERASED_WORD;
  assign page_match  = page_ok(page_select_reg) && (page_word == data_word);
  assign timing_word = {erase_timing_high, erase_timing_low};
  assign half_word   = (timing_word[15:1] == 15'h0) ? 16'h0001 : {1'b0, timing_word[15:1]};
  assign tick        = (pre_cnt_reg >= half_word - 16'h0001);
  assign timed_cmd   = (sfr_wdata == CMD_PROGRAM) || (sfr_wdata == CMD_ERASE) ||
                       (sfr_wdata == CMD_ERASE_ALL);

  // configuration registers, written only while the sequencer is idle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      page_select_reg   <= RESET_BYTE;
      erase_timing_low  <= TIMING_RESET[7:0];
      erase_timing_high <= TIMING_RESET[15:8];
      third_timing_reg  <= THIRD_RESET;
    end else if (ce && sfr_wr && idle) begin
      case (sfr_addr)
        ADDR_PAGE:      page_select_reg   <= sfr_wdata;
        ADDR_TIM_LOW:   erase_timing_low  <= sfr_wdata;
        ADDR_TIM_HIGH:  erase_timing_high <= sfr_wdata;
        ADDR_TIM_THIRD: third_timing_reg  <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // page data registers: bus writes and page read
  generate
    for (genvar b = 0; b < 4; b++) begin : g_data
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          data_reg[b] <= RESET_BYTE;
        end else if (ce && idle) begin
          if (cmd_wr && sfr_wdata == CMD_READ && page_ok(page_select_reg)) begin
            data_reg[b] <= page_word[8*b +: 8];
          end else if (sfr_wr && sfr_addr == ADDR_DATA_ONE + 8'(b)) begin
            data_reg[b] <= sfr_wdata;
          end
        end
      end
    end
  endgenerate

  // command register and verify result
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      command_reg <= RESET_BYTE;
    end else if (ce) begin
      if (cmd_wr) begin
        if (sfr_wdata == CMD_VERIFY) begin
          command_reg <= page_match ? CMD_DONE : VERIFY_FAIL;
        end else begin
          command_reg <= sfr_wdata;
        end
      end else if (state_reg == ST_APPLY) begin
        command_reg <= CMD_DONE;
      end
    end
  end

  // sequencer state machine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= ST_IDLE;
      op_reg          <= CMD_DONE;
      op_page_reg     <= RESET_BYTE;
      op_data_reg     <= 32'h0;
      tick_target_reg <= 9'h0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_wr && timed_cmd) begin
            state_reg       <= ST_WAIT;
            op_reg          <= sfr_wdata;
            op_page_reg     <= page_select_reg;
            op_data_reg     <= data_word;
            tick_target_reg <= (sfr_wdata == CMD_PROGRAM) ? PROG_TICKS : ERASE_TICKS;
          end
        end
        ST_WAIT: begin
          if (tick && tick_cnt_reg == tick_target_reg - 9'h001) begin
            state_reg <= ST_APPLY;
          end
        end
        ST_APPLY: state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // duration counters: prescaler to 50 us ticks, then tick count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_reg  <= 16'h0;
      tick_cnt_reg <= 9'h0;
    end else if (ce) begin
      if (state_reg != ST_WAIT) begin
        pre_cnt_reg  <= 16'h0;
        tick_cnt_reg <= 9'h0;
      end else if (tick) begin
        pre_cnt_reg  <= 16'h0;
        tick_cnt_reg <= tick_cnt_reg + 9'h001;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 16'h0001;
      end
    end
  end

  // array cells: committed only when the timed operation ends
  generate
    for (genvar p = 0; p < PAGES; p++) begin : g_page
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mem_reg[p] <= ERASED_WORD;
        end else if (ce && state_reg == ST_APPLY) begin
          if (op_reg == CMD_ERASE_ALL) begin
            mem_reg[p] <= ERASED_WORD;
          end else if (op_page_reg == 8'(p)) begin
            if (op_reg == CMD_ERASE) begin
              mem_reg[p] <= ERASED_WORD;
            end else if (op_reg == CMD_PROGRAM) begin
              mem_reg[p] <= op_data_reg;
            end
          end
        end
      end
    end
  endgenerate

  // registered outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy      <= 1'b0;
      sfr_rdata <= RESET_BYTE;
    end else if (ce) begin
      busy <= (cmd_wr && timed_cmd) || (state_reg == ST_WAIT);
      case (sfr_addr)
        ADDR_COMMAND:   sfr_rdata <= command_reg;
        ADDR_DATA_ONE:  sfr_rdata <= data_reg[0];
        ADDR_DATA_TWO:  sfr_rdata <= data_reg[1];
        ADDR_DATA_THR:  sfr_rdata <= data_reg[2];
        ADDR_DATA_FOUR: sfr_rdata <= data_reg[3];
        ADDR_PAGE:      sfr_rdata <= page_select_reg;
        ADDR_TIM_LOW:   sfr_rdata <= erase_timing_low;
        ADDR_TIM_HIGH:  sfr_rdata <= erase_timing_high;
        ADDR_TIM_THIRD: sfr_rdata <= third_timing_reg;
        default:        sfr_rdata <= RESET_BYTE;
      endcase
    end
  end

  // checks
  property p_read_now;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata == CMD_READ && page_ok(page_select_reg)
    |=> data_word == $past(page_word) && !busy;
  endproperty
  a_read_now: assert property (p_read_now) else $error("page read wrong or busy");

  property p_timed_busy;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && timed_cmd |=> busy && state_reg == ST_WAIT;
  endproperty
  a_timed_busy: assert property (p_timed_busy) else $error("timed command not started");

  property p_busy_hold;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_WAIT |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_duration;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_APPLY |-> tick_cnt_reg == tick_target_reg;
  endproperty
  a_duration: assert property (p_duration) else $error("operation ended at wrong tick");

  property p_prog_target;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata == CMD_PROGRAM |=> tick_target_reg == PROG_TICKS;
  endproperty
  a_prog_target: assert property (p_prog_target) else $error("program length not 250 us");

  property p_verify;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata == CMD_VERIFY
    |=> (command_reg == CMD_DONE) == $past(page_match);
  endproperty
  a_verify: assert property (p_verify) else $error("verify result wrong");

  property p_erase_page;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_APPLY && op_reg == CMD_ERASE && page_ok(op_page_reg)
    |=> mem_reg[$past(op_page_reg)] == ERASED_WORD;
  endproperty
  a_erase_page: assert property (p_erase_page) else $error("page not erased");

  property p_erase_all;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_APPLY && op_reg == CMD_ERASE_ALL
    |=> mem_reg[0] == ERASED_WORD && mem_reg[PAGES-1] == ERASED_WORD;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("array not erased");

  property p_program;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_APPLY && op_reg == CMD_PROGRAM && page_ok(op_page_reg)
    |=> mem_reg[$past(op_page_reg)] == $past(op_data_reg);
  endproperty
  a_program: assert property (p_program) else $error("page not programmed");

  property p_reserved;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && (sfr_wdata == CMD_INTERNAL || sfr_wdata > CMD_ERASE_ALL || sfr_wdata == CMD_DONE)
    |=> $stable(data_word) && idle && !busy;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_page_stable;
    @(posedge clk_sys) disable iff (!resetn)
    !idle |=> $stable(page_select_reg) && $stable(erase_timing_low);
  endproperty
  a_page_stable: assert property (p_page_stable) else $error("setup changed while busy");

  property p_erase_target;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && (sfr_wdata == CMD_ERASE || sfr_wdata == CMD_ERASE_ALL)
    |=> tick_target_reg == ERASE_TICKS;
  endproperty
  a_erase_target: assert property (p_erase_target) else $error("erase length wrong");

  property p_busy_end;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_APPLY |=> !busy && idle;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy outlived operation");

  property p_untimed;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && (sfr_wdata == CMD_READ || sfr_wdata == CMD_VERIFY) |=> !busy && idle;
  endproperty
  a_untimed: assert property (p_untimed) else $error("read or verify went busy");

  property p_read_range;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata == CMD_READ && !page_ok(page_select_reg) |=> $stable(data_word);
  endproperty
  a_read_range: assert property (p_read_range) else $error("read of missing page");

  property p_verify_range;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata == CMD_VERIFY && !page_ok(page_select_reg)
    |=> command_reg != CMD_DONE;
  endproperty
  a_verify_range: assert property (p_verify_range) else $error("missing page verified");

  property p_tick_bound;
    @(posedge clk_sys) disable iff (!resetn)
    ce && state_reg == ST_WAIT |-> pre_cnt_reg < half_word && tick_cnt_reg < tick_target_reg;
  endproperty
  a_tick_bound: assert property (p_tick_bound) else $error("duration counter overran");

  property p_code_kept;
    @(posedge clk_sys) disable iff (!resetn)
    cmd_wr && sfr_wdata != CMD_VERIFY |=> command_reg == $past(sfr_wdata);
  endproperty
  a_code_kept: assert property (p_code_kept) else $error("command code lost");

  property p_ce_freeze;
    @(posedge clk_sys) disable iff (!resetn)
    !ce |=> $stable(state_reg) && $stable(busy) && $stable(page_select_reg);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("frozen state moved");

endmodule : dfps_sequencer
`default_nettype wire

//--- dv/dfps_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dfps_core_model (
  // clock
  input  wire logic       clk_sys,
  // special function register bus
  output var  logic [7:0] sfr_addr,
  output var  logic       sfr_wr,
  output var  logic [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  // stall
  input  wire logic       busy
);
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
  end
  // core stays stalled while busy is high, which includes the apply cycle
  task automatic idle_wait();
    @(negedge clk_sys);
    while (busy !== 1'b0) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : idle_wait
  // command codes come from the caller only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle_wait();
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    idle_wait();
    sfr_addr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = sfr_rdata;
  endtask : rd
endmodule : dfps_core_model
`default_nettype wire

//--- dv/data_flash_page_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module data_flash_page_sequencer_tb;
  import dfps_pkg::*;
  localparam int TICK = 2;
  logic       clk_sys;
  logic       resetn;
  logic       ce;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       busy;
  int         n_fail;
  int         total_checks;
  int         busy_cycles;
  logic [7:0] ra [10] = '{8'hB9, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC6, 8'hC4, 8'hC5, 8'hC7, 8'hC0};
  logic [7:0] re [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h52, 8'h04, 8'hC9, 8'h00};
  logic [7:0] rc [4]  = '{8'h03, 8'h07, 8'hFF, 8'h00};

  dfps_sequencer i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .busy(busy));
  dfps_core_model i_core (
    .clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .busy(busy));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (busy === 1'b1) busy_cycles <= busy_cycles + 1;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_core.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic load(input logic [7:0] pg, input logic [31:0] w);
    i_core.wr(8'hC6, pg);
    for (int i = 0; i < 4; i++) i_core.wr(8'hBC + 8'(i), w[8*i +: 8]);
  endtask : load
  task automatic expect_page(input logic [31:0] w);
    for (int i = 0; i < 4; i++) rchk(8'hBC + 8'(i), w[8*i +: 8]);
  endtask : expect_page
  task automatic read_page(input logic [7:0] pg, input logic [31:0] w);
    i_core.wr(8'hC6, pg);
    busy_cycles = 0;
    i_core.wr(8'hB9, 8'h01);
    rchk(8'hB9, 8'h01);
    chk(8'(busy_cycles), 8'h00);
    expect_page(w);
  endtask : read_page
  task automatic timed(input logic [7:0] cmd, input int ticks);
    busy_cycles = 0;
    i_core.wr(8'hB9, cmd);
    rchk(8'hB9, 8'h00);
    chk({7'h00, busy_cycles >= ticks * TICK && busy_cycles <= ticks * TICK + 2}, 8'h01);
  endtask : timed

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    total_checks = 0;
    busy_cycles = 0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(ra[i], re[i]);
    $display("test reset values done");
    i_core.wr(8'hC4, 8'h04);
    i_core.wr(8'hC5, 8'h00);
    load(8'h9F, 32'h4433_2211);
    timed(8'h02, 5);
    load(8'h9F, 32'h0000_0000);
    read_page(8'h9F, 32'h4433_2211);
    i_core.wr(8'hB9, 8'h04);
    rchk(8'hB9, 8'h00);
    i_core.wr(8'hBD, 8'h55);
    i_core.wr(8'hB9, 8'h04);
    rchk(8'hB9, VERIFY_FAIL);
    read_page(8'h9E, ERASED_WORD);
    $display("test program read verify done");
    load(8'h00, 32'h8765_4321);
    timed(8'h02, 5);
    i_core.wr(8'hC6, 8'h9F);
    timed(8'h05, 400);
    read_page(8'h9F, ERASED_WORD);
    read_page(8'h00, 32'h8765_4321);
    timed(8'h06, 400);
    read_page(8'h00, ERASED_WORD);
    $display("test erase done");
    load(8'h00, 32'hCAFE_BA5E);
    for (int i = 0; i < 4; i++) begin
      busy_cycles = 0;
      i_core.wr(8'hB9, rc[i]);
      expect_page(32'hCAFE_BA5E);
      chk(8'(busy_cycles), 8'h00);
    end
    read_page(8'h00, ERASED_WORD);
    $display("test reserved codes done");
    @(posedge clk_sys);
    ce <= 1'b0;
    busy_cycles = 0;
    i_core.wr(8'hC6, 8'h5A);
    i_core.wr(8'hB9, 8'h02);
    ce <= 1'b1;
    chk(8'(busy_cycles), 8'h00);
    rchk(8'hC6, 8'h00);
    rchk(8'hB9, 8'h01);
    i_core.wr(8'hC6, 8'hA0);
    i_core.wr(8'hB9, 8'h04);
    rchk(8'hB9, VERIFY_FAIL);
    i_core.wr(8'hBC, 8'h12);
    i_core.wr(8'hB9, 8'h01);
    rchk(8'hBC, 8'h12);
    $display("test clock enable and page range done");
    end_sim();
  end

  initial begin
    #250000;
    n_fail++;
    end_sim();
  end
endmodule : data_flash_page_sequencer_tb
`default_nettype wire
